// file: core/gwm_monitor.v
// Warning-level fault monitor of a generator set controller.
// Measurements and settings come from logic on clk_in; contactor
// feedback and the two service buttons are raw pins.
`timescale 1ns/10ps
`default_nettype none
`include "gwm_defines.vh"
module gwm_monitor #(
   parameter TICK_CYCLES = `GWM_MS_CYCLES
) (
   input wire clk_in,
   input wire rst_in,
   // Configuration
   input wire latch_all_in,
   input wire warn_clear_in,
   input wire [15:0] holdoff_ms_in,
   // Frequency
   input wire [15:0] freq_in,
   input wire [15:0] freq_lo_in,
   input wire [15:0] freq_hi_in,
   input wire [15:0] freq_delay_in,
   // Speed
   input wire [15:0] rpm_in,
   input wire [15:0] rpm_lo_in,
   input wire [15:0] rpm_hi_in,
   input wire [15:0] rpm_overshoot_in,
   input wire [15:0] rpm_delay_in,
   input wire [15:0] crank_cut_rpm_in,
   input wire [15:0] speed_signal_loss_delay_in,
   input wire speed_loss_stop_in,
   // Phase voltages and currents
   input wire [15:0] volt_a_in,
   input wire [15:0] volt_b_in,
   input wire [15:0] volt_c_in,
   input wire [15:0] volt_lo_in,
   input wire [15:0] volt_hi_in,
   input wire [15:0] volt_delay_in,
   input wire [15:0] unbal_lim_in,
   input wire [15:0] cur_a_in,
   input wire [15:0] cur_b_in,
   input wire [15:0] cur_c_in,
   input wire cur_unbal_stop_in,
   input wire [15:0] overcur_lim_in,
   input wire [23:0] inverse_time_curve_in,
   // Battery and charge alternator
   input wire [15:0] batt_in,
   input wire [15:0] batt_lo_in,
   input wire [15:0] batt_hi_in,
   input wire [15:0] batt_delay_in,
   input wire [15:0] charge_in,
   input wire [15:0] charge_lo_in,
   // Power
   input wire signed [15:0] power_in,
   input wire [15:0] rev_power_lim_in,
   input wire [15:0] rev_power_delay_in,
   // Engine state
   input wire engine_running_in,
   input wire stop_request_in,
   input wire [15:0] stop_time_in,
   input wire fuel_on_in,
   input wire [15:0] ecu_fault_code_in,
   // Mains phase order
   input wire phase_check_en_in,
   input wire mains_present_in,
   input wire mains_reversed_in,
   // Contactors, feedback are pins
   input wire [15:0] contactor_delay_in,
   input wire mains_fb_assigned_in,
   input wire mains_close_cmd_in,
   input wire mains_fb_pin_in,
   input wire gen_fb_assigned_in,
   input wire gen_close_cmd_in,
   input wire gen_fb_pin_in,
   // Service, storage, readiness
   input wire service_expired_in,
   input wire svc_button_a_pin_in,
   input wire svc_button_b_pin_in,
   input wire nv_write_fail_in,
   input wire auto_mode_in,
   input wire fault_present_in,
   input wire schedule_block_in,
   // Results
   output wire [`GWM_W_COUNT-1:0] warn_out,
   output wire stop_out,
   output wire mains_close_inhibit_out,
   output wire service_reset_out,
   output wire holdoff_done_out
);
   // Absolute difference of two values
   function [15:0] abs_diff;
      input [15:0] x;
      input [15:0] y;
      begin
         abs_diff = (x > y) ? (x - y) : (y - x);
      end
   endfunction

   // True when any phase strays from the mean by more than lim
   function unbal;
      input [15:0] a;
      input [15:0] b;
      input [15:0] c;
      input [15:0] lim;
      reg [17:0] sum;
      reg [17:0] avg;
      begin
         sum = {2'b00, a} + {2'b00, b} + {2'b00, c};
         avg = sum / 18'h00003;
         unbal = (abs_diff(a, avg[15:0]) > lim) |
                 (abs_diff(b, avg[15:0]) > lim) |
                 (abs_diff(c, avg[15:0]) > lim);
      end
   endfunction

   // Largest of three phases
   function [15:0] max3;
      input [15:0] a;
      input [15:0] b;
      input [15:0] c;
      reg [15:0] m;
      begin
         m = (a > b) ? a : b;
         max3 = (m > c) ? m : c;
      end
   endfunction

   reg [`GWM_TICK_W-1:0] tick_cnt_q;
   reg tick_q;
   reg [15:0] hold_cnt_q;
   reg hold_done_q;
   reg [23:0] oc_acc_q;
   reg oc_trip_q;
   reg [`GWM_W_COUNT-1:0] flags_q;
   reg [`GWM_W_COUNT-1:0] flags_d;
   reg stop_q;
   reg inhibit_q;
   reg btn_done_q;
   reg svc_reset_q;

   wire [3:0] pins_s;
   wire mains_fb_s;
   wire gen_fb_s;
   wire btn_both_s;
   wire [`GWM_T_COUNT-1:0] tcond;
   wire [`GWM_T_COUNT-1:0] tdone;
   wire [`GWM_T_COUNT*`GWM_DLY_W-1:0] tdly;
   wire [`GWM_W_COUNT-1:0] raw;
   wire [31:0] freq_scaled;
   wire [31:0] freq_limit;
   wire freq_over;
   wire rpm_over;
   wire [15:0] cur_max;
   wire over_cur;
   wire [15:0] rev_mag;
   wire rev_over;
   wire run;
   wire hold;

   // Contactor feedback and buttons cross in from the pins
   gwm_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pin_in({svc_button_b_pin_in, svc_button_a_pin_in,
               gen_fb_pin_in, mains_fb_pin_in}),
      .sync_out(pins_s)
   );

   assign mains_fb_s = pins_s[0];
   assign gen_fb_s = pins_s[1];
   assign btn_both_s = pins_s[2] & pins_s[3];
   assign run = engine_running_in;
   assign hold = hold_done_q;

   // Millisecond tick shared by every delay
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tick_cnt_q <= {`GWM_TICK_W{1'b0}};
         tick_q <= 1'b0;
      end
      else if (tick_cnt_q == TICK_CYCLES[`GWM_TICK_W-1:0] - 18'h00001)
      begin
         tick_cnt_q <= {`GWM_TICK_W{1'b0}};
         tick_q <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 18'h00001;
         tick_q <= 1'b0;
      end
   end

   // Holdoff runs from first running indication, clears on stop
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         hold_cnt_q <= 16'h0000;
         hold_done_q <= 1'b0;
      end
      else if (!run)
      begin
         hold_cnt_q <= 16'h0000;
         hold_done_q <= 1'b0;
      end
      else
      begin
         if (tick_q && (hold_cnt_q < holdoff_ms_in))
            hold_cnt_q <= hold_cnt_q + 16'h0001;
         hold_done_q <= (hold_cnt_q >= holdoff_ms_in);
      end
   end

   // Overfrequency shutdown compares f*100 against hi*112
   assign freq_scaled = {16'h0000, freq_in} * `GWM_PCT_BASE;
   assign freq_limit = {16'h0000, freq_hi_in} * `GWM_OVERSHOOT_PCT;
   assign freq_over = freq_scaled > freq_limit;
   assign rpm_over = rpm_in > rpm_overshoot_in;

   assign cur_max = max3(cur_a_in, cur_b_in, cur_c_in);
   assign over_cur = cur_max > overcur_lim_in;
   assign rev_mag = power_in[15] ? (16'h0000 - power_in) : 16'h0000;
   assign rev_over = power_in[15] && (rev_mag > rev_power_lim_in);

   // Conditions that need a dedicated delay timer
   assign tcond[0] = hold && (freq_in < freq_lo_in);
   assign tcond[1] = hold && (freq_in > freq_hi_in);
   assign tcond[2] = hold && (rpm_in < rpm_lo_in);
   assign tcond[3] = hold && (rpm_in > rpm_hi_in);
   assign tcond[4] = hold && ((volt_a_in < volt_lo_in) || (volt_a_in > volt_hi_in) ||
                              (volt_b_in < volt_lo_in) || (volt_b_in > volt_hi_in) ||
                              (volt_c_in < volt_lo_in) || (volt_c_in > volt_hi_in));
   assign tcond[5] = batt_in < batt_lo_in;
   assign tcond[6] = batt_in > batt_hi_in;
   assign tcond[7] = stop_request_in;
   assign tcond[8] = hold && unbal(volt_a_in, volt_b_in, volt_c_in, unbal_lim_in);
   assign tcond[9] = hold && unbal(cur_a_in, cur_b_in, cur_c_in, unbal_lim_in);
   assign tcond[10] = rev_over;
   assign tcond[11] = mains_fb_assigned_in && (mains_close_cmd_in != mains_fb_s);
   assign tcond[12] = gen_fb_assigned_in && (gen_close_cmd_in != gen_fb_s);
   assign tcond[13] = run && (rpm_in < crank_cut_rpm_in);
   assign tcond[14] = btn_both_s;

   // Delay settings in slot order, highest slot first
   assign tdly = {`GWM_SVC_HOLD_MS, speed_signal_loss_delay_in,
                  contactor_delay_in, contactor_delay_in,
                  rev_power_delay_in, volt_delay_in, volt_delay_in,
                  stop_time_in, batt_delay_in, batt_delay_in,
                  volt_delay_in, rpm_delay_in, rpm_delay_in,
                  freq_delay_in, freq_delay_in};

   genvar gi;
   generate
      for (gi = 0; gi < `GWM_T_COUNT; gi = gi + 1)
      begin : g_tmr
         gwm_delay_timer u_tmr (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .tick_in(tick_q),
            .cond_in(tcond[gi]),
            .delay_in(tdly[gi*`GWM_DLY_W +: `GWM_DLY_W]),
            .done_out(tdone[gi])
         );
      end
   endgenerate

   // Inverse-time overcurrent: excess over the limit is integrated
   // each millisecond, so a larger excess trips sooner. Dropping
   // below the limit discards the sum without a flag.
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         oc_acc_q <= 24'h000000;
         oc_trip_q <= 1'b0;
      end
      else if (!over_cur)
      begin
         oc_acc_q <= 24'h000000;
         oc_trip_q <= 1'b0;
      end
      else
      begin
         if (tick_q && (oc_acc_q < inverse_time_curve_in))
            oc_acc_q <= oc_acc_q + {8'h00, cur_max - overcur_lim_in};
         oc_trip_q <= (oc_acc_q >= inverse_time_curve_in);
      end
   end

   // Raw warning causes
   assign raw[`GWM_W_FREQ_LO] = tdone[0];
   assign raw[`GWM_W_FREQ_HI] = tdone[1];
   assign raw[`GWM_W_RPM_LO] = tdone[2];
   assign raw[`GWM_W_RPM_HI] = tdone[3];
   assign raw[`GWM_W_VOLT] = tdone[4];
   assign raw[`GWM_W_BATT_LO] = tdone[5];
   assign raw[`GWM_W_BATT_HI] = tdone[6];
   assign raw[`GWM_W_FAIL_STOP] = tdone[7] && run;
   assign raw[`GWM_W_CHARGE_LO] = hold && (charge_in < charge_lo_in);
   assign raw[`GWM_W_ECU] = ecu_fault_code_in != 16'h0000;
   assign raw[`GWM_W_V_UNBAL] = tdone[8];
   assign raw[`GWM_W_I_UNBAL] = tdone[9];
   assign raw[`GWM_W_OVERCUR] = oc_trip_q;
   assign raw[`GWM_W_REV_PWR] = tdone[10];
   assign raw[`GWM_W_PHASE_ORD] = phase_check_en_in && mains_present_in &&
                                  mains_reversed_in;
   assign raw[`GWM_W_MCB_OPEN] = tdone[11] && !mains_close_cmd_in;
   assign raw[`GWM_W_MCB_CLOSE] = tdone[11] && mains_close_cmd_in;
   assign raw[`GWM_W_GCB_OPEN] = tdone[12] && !gen_close_cmd_in;
   assign raw[`GWM_W_GCB_CLOSE] = tdone[12] && gen_close_cmd_in;
   assign raw[`GWM_W_SPD_LOSS] = tdone[13];
   assign raw[`GWM_W_SERVICE] = service_expired_in;
   assign raw[`GWM_W_NV_FAIL] = nv_write_fail_in;
   assign raw[`GWM_W_FUEL_OFF] = run && !fuel_on_in;
   assign raw[`GWM_W_NOT_READY] = !auto_mode_in || fault_present_in ||
                                  schedule_block_in;

   // A cause present in the clear cycle keeps its flag set
   always @*
   begin
      flags_d = raw | (flags_q & {`GWM_W_COUNT{latch_all_in & ~warn_clear_in}});
   end

   // Flags, stop demand and contactor inhibit
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         flags_q <= `GWM_FLAGS_RST;
         stop_q <= 1'b0;
         inhibit_q <= 1'b0;
      end
      else
      begin
         flags_q <= flags_d;
         // Engine unit faults never reach the stop demand
         stop_q <= freq_over | rpm_over |
                   (cur_unbal_stop_in & tdone[9]) |
                   (speed_loss_stop_in & tdone[13]);
         inhibit_q <= raw[`GWM_W_PHASE_ORD];
      end
   end

   // One pulse per completed two-button hold
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         btn_done_q <= 1'b0;
         svc_reset_q <= 1'b0;
      end
      else
      begin
         btn_done_q <= tdone[14];
         svc_reset_q <= tdone[14] & ~btn_done_q;
      end
   end

   assign warn_out = flags_q;
   assign stop_out = stop_q;
   assign mains_close_inhibit_out = inhibit_q;
   assign service_reset_out = svc_reset_q;
   assign holdoff_done_out = hold_done_q;
endmodule
`default_nettype wire

// file: include/gwm_defines.vh
// Constants for the generator warning monitor.
// Assumes a 250 MHz system clock and millisecond-based delays.
`ifndef GWM_DEFINES_VH
`define GWM_DEFINES_VH

// Timing
`define GWM_CLK_NS 4
`define GWM_MS_NS 1000000
`define GWM_MS_CYCLES (`GWM_MS_NS / `GWM_CLK_NS)
`define GWM_SVC_HOLD_MS 16'h1388
`define GWM_TICK_W 18

// Overfrequency shutdown ratio, percent
`define GWM_PCT_BASE 32'h00000064
`define GWM_OVERSHOOT_PCT 32'h00000070

// Warning flag positions
`define GWM_W_FREQ_LO 0
`define GWM_W_FREQ_HI 1
`define GWM_W_RPM_LO 2
`define GWM_W_RPM_HI 3
`define GWM_W_VOLT 4
`define GWM_W_BATT_LO 5
`define GWM_W_BATT_HI 6
`define GWM_W_FAIL_STOP 7
`define GWM_W_CHARGE_LO 8
`define GWM_W_ECU 9
`define GWM_W_V_UNBAL 10
`define GWM_W_I_UNBAL 11
`define GWM_W_OVERCUR 12
`define GWM_W_REV_PWR 13
`define GWM_W_PHASE_ORD 14
`define GWM_W_MCB_OPEN 15
`define GWM_W_MCB_CLOSE 16
`define GWM_W_GCB_OPEN 17
`define GWM_W_GCB_CLOSE 18
`define GWM_W_SPD_LOSS 19
`define GWM_W_SERVICE 20
`define GWM_W_NV_FAIL 21
`define GWM_W_FUEL_OFF 22
`define GWM_W_NOT_READY 23
`define GWM_W_COUNT 24
`define GWM_FLAGS_RST 24'h000000

// Delay timer slots
`define GWM_T_COUNT 15
`define GWM_DLY_W 16

`endif

// file: core/gwm_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins change slowly relative to the system clock.
`timescale 1ns/10ps
`default_nettype none
module gwm_sync #(
   parameter WIDTH = 4
) (
   input wire clk_in,
   input wire rst_in,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// file: core/gwm_delay_timer.v
// Restartable millisecond delay qualifier.
// Assumes tick_in pulses once per millisecond on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "gwm_defines.vh"
module gwm_delay_timer (
   input wire clk_in,
   input wire rst_in,
   input wire tick_in,
   input wire cond_in,
   input wire [`GWM_DLY_W-1:0] delay_in,
   output wire done_out
);
   reg [`GWM_DLY_W-1:0] cnt_q;
   reg done_q;

   // Any drop of the condition restarts the count
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_q <= {`GWM_DLY_W{1'b0}};
         done_q <= 1'b0;
      end
      else if (!cond_in)
      begin
         cnt_q <= {`GWM_DLY_W{1'b0}};
         done_q <= 1'b0;
      end
      else
      begin
         // Saturates at the delay so a long fault cannot wrap
         if (tick_in && (cnt_q < delay_in))
            cnt_q <= cnt_q + 16'h0001;
         done_q <= (cnt_q >= delay_in);
      end
   end

   assign done_out = done_q;
endmodule
`default_nettype wire

// file: verif/gwm_monitor_properties.sv
// Port checker for the generator warning monitor.
// Assumes one clock domain; bound to every monitor instance.
`timescale 1ns/10ps
`default_nettype none
`include "gwm_defines.vh"
module gwm_monitor_chk (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic latch_all_in,
   input wire logic warn_clear_in,
   input wire logic [15:0] freq_in,
   input wire logic [15:0] freq_hi_in,
   input wire logic [15:0] rpm_in,
   input wire logic [15:0] rpm_overshoot_in,
   input wire logic engine_running_in,
   input wire logic fuel_on_in,
   input wire logic [15:0] ecu_fault_code_in,
   input wire logic phase_check_en_in,
   input wire logic mains_present_in,
   input wire logic mains_reversed_in,
   input wire logic nv_write_fail_in,
   input wire logic auto_mode_in,
   input wire logic fault_present_in,
   input wire logic schedule_block_in,
   input wire logic [23:0] warn_out,
   input wire logic stop_out,
   input wire logic mains_close_inhibit_out,
   input wire logic service_reset_out,
   input wire logic holdoff_done_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // A latched flag survives its cause unless a clear is given
   chk_latch_hold: assert property (latch_all_in && !warn_clear_in && warn_out[`GWM_W_NV_FAIL]
      |=> warn_out[`GWM_W_NV_FAIL]) else $error("latched flag dropped");
   // Overfrequency stop uses the 112 percent ratio exactly
   chk_overfreq_stop: assert property ({16'h0000, freq_in} * `GWM_PCT_BASE
      > {16'h0000, freq_hi_in} * `GWM_OVERSHOOT_PCT |=> stop_out) else $error("no overfrequency stop");
   chk_overspeed_stop: assert property (rpm_in > rpm_overshoot_in |=> stop_out)
      else $error("no overspeed stop");
   chk_ecu_flag: assert property (ecu_fault_code_in != 16'h0000 |=> warn_out[`GWM_W_ECU])
      else $error("engine unit fault not flagged");
   chk_phase_inhibit: assert property (phase_check_en_in && mains_present_in && mains_reversed_in
      |=> mains_close_inhibit_out && warn_out[`GWM_W_PHASE_ORD]) else $error("phase order not handled");
   chk_svc_single: assert property (service_reset_out |=> !service_reset_out [*8])
      else $error("service reset repeated");
   chk_nv_flag: assert property (nv_write_fail_in |=> warn_out[`GWM_W_NV_FAIL])
      else $error("storage failure not flagged");
   chk_fuel_flag: assert property (engine_running_in && !fuel_on_in |=> warn_out[`GWM_W_FUEL_OFF])
      else $error("fuel off not flagged");
   chk_not_ready: assert property (!auto_mode_in || fault_present_in || schedule_block_in
      |=> warn_out[`GWM_W_NOT_READY]) else $error("not ready missing");
   chk_holdoff_drop: assert property (!engine_running_in |=> !holdoff_done_out)
      else $error("holdoff kept after stop");
endmodule
bind gwm_monitor gwm_monitor_chk i_gwm_monitor_chk (.*);
`default_nettype wire

// file: verif/gwm_contactor_model.sv
// Contactor model: auxiliary contact follows the coil command.
// Assumes the same clock as the monitor; a jammed contact holds.
`timescale 1ns/10ps
`default_nettype none
module gwm_contactor_model #(
   parameter LAG = 3
) (
   input wire logic clk_in,
   input wire logic close_cmd_in,
   input wire logic stuck_in,
   output var logic fb_out
);
   logic [LAG-1:0] travel_q = '0;
   initial fb_out = 1'b0;
   // Travel time keeps feedback later than the command, as real poles
   always @(posedge clk_in)
   begin
      travel_q <= {travel_q[LAG-2:0], close_cmd_in};
      if (!stuck_in)
         fb_out <= travel_q[LAG-1];
   end
endmodule
`default_nettype wire

// file: verif/gwm_monitor_bench.sv
// Self-checking bench for the generator warning monitor.
// Assumes a shortened ms tick; contactor pins come from models.
`timescale 1ns/10ps
`default_nettype none
module gwm_monitor_bench;
   localparam TK = 4;
   logic clk_in = 1'b0, rst_in = 1'b1, latch_all_in = 1'b0, warn_clear_in = 1'b0, probe_q = 1'b0;
   logic speed_loss_stop_in = 1'b1, cur_unbal_stop_in = 1'b1, engine_running_in = 1'b0;
   logic stop_request_in = 1'b0, fuel_on_in = 1'b1, phase_check_en_in = 1'b1, mains_present_in = 1'b1;
   logic mains_reversed_in = 1'b0, mains_fb_assigned_in = 1'b1, mains_close_cmd_in = 1'b0;
   logic gen_fb_assigned_in = 1'b1, gen_close_cmd_in = 1'b0, service_expired_in = 1'b0, svc_seen = 1'b0;
   logic svc_button_a_pin_in = 1'b0, svc_button_b_pin_in = 1'b0, nv_write_fail_in = 1'b0;
   logic auto_mode_in = 1'b1, fault_present_in = 1'b0, schedule_block_in = 1'b0, gen_stuck = 1'b0;
   logic [15:0] holdoff_ms_in = 16'h0002, freq_in = 16'h01F4, freq_lo_in = 16'h0190, freq_hi_in = 16'h0258;
   logic [15:0] rpm_in = 16'h05DC, rpm_lo_in = 16'h0500, rpm_hi_in = 16'h0700, rpm_overshoot_in = 16'h0800;
   logic [15:0] crank_cut_rpm_in = 16'h0100, volt_a_in = 16'h00E6, volt_b_in = 16'h00E6, volt_c_in = 16'h00E6;
   logic [15:0] volt_lo_in = 16'h0096, volt_hi_in = 16'h012C, unbal_lim_in = 16'h0014, cur_a_in = 16'h0064;
   logic [15:0] cur_b_in = 16'h0064, cur_c_in = 16'h0064, overcur_lim_in = 16'h0190, batt_in = 16'h00C0;
   logic [15:0] batt_lo_in = 16'h00A0, batt_hi_in = 16'h00F0, charge_in = 16'h00C0, charge_lo_in = 16'h00A0;
   logic [15:0] rev_power_lim_in = 16'h0064, ecu_fault_code_in = 16'h0000, freq_delay_in = 16'h0002;
   logic [15:0] rpm_delay_in = 16'h0002, speed_signal_loss_delay_in = 16'h0002, volt_delay_in = 16'h0002;
   logic [15:0] batt_delay_in = 16'h0002, rev_power_delay_in = 16'h0002, stop_time_in = 16'h0002;
   // Longer than contact travel plus sync, so a healthy contactor never warns
   logic [15:0] contactor_delay_in = 16'h0003;
   logic [23:0] inverse_time_curve_in = 24'h000010;
   logic signed [15:0] power_in = 16'sh0000;
   logic [31:0] seed = 32'hEF57904C;
   logic [27:0] exp_q[$], msk_q[$], obs, expv;
   int error_cnt = 0, check_count = 0, cyc = 0;
   int tb_bits[22] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16, 19, 20, 21, 22, 23, 18};
   wire logic mains_fb_pin_in, gen_fb_pin_in, stop_out, mains_close_inhibit_out;
   wire logic service_reset_out, holdoff_done_out;
   wire logic [23:0] warn_out;
   wire logic [27:0] outs = {svc_seen, holdoff_done_out, mains_close_inhibit_out, stop_out, warn_out};
   gwm_monitor #(.TICK_CYCLES(TK)) i_gwm_monitor (.*);
   // Mains contact is jammed open so its close command must fail
   gwm_contactor_model i_mains_cb (.clk_in(clk_in), .close_cmd_in(mains_close_cmd_in), .stuck_in(1'b1),
      .fb_out(mains_fb_pin_in));
   gwm_contactor_model i_gen_cb (.clk_in(clk_in), .close_cmd_in(gen_close_cmd_in), .stuck_in(gen_stuck),
      .fb_out(gen_fb_pin_in));
   always #2 clk_in = ~clk_in;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Note one output bit; the bench checker block judges it at the next edge
   task automatic note(input int b, input logic v);
      exp_q.push_back(28'(v) << b);
      msk_q.push_back(28'h1 << b);
      probe_q <= 1'b1;
      @(posedge clk_in);
      probe_q <= 1'b0;
      @(posedge clk_in);
   endtask
   // Flag must stay low before lo cycles and appear within hi more
   task automatic rise(input int b, input int lo, input int hi);
      int n;
      n = 0;
      if (lo > 1)
      begin
         tick(lo - 2);
         note(b, 1'b0);
      end
      while (outs[b] !== 1'b1 && n < hi)
      begin
         @(posedge clk_in);
         n++;
      end
      note(b, 1'b1);
   endtask
   // Drive the cause of warning bit b, or take it away
   task automatic set_cause(input int b, input logic v);
      seed = xs(seed);
      case (b)
         0: freq_in <= v ? 16'h0100 : 16'h01F4;
         1: freq_in <= v ? 16'h0280 : 16'h01F4;
         2: rpm_in <= v ? 16'h0400 : 16'h05DC;
         3: rpm_in <= v ? 16'h0780 : 16'h05DC;
         4: volt_a_in <= v ? 16'h0140 : 16'h00E6;
         5: batt_in <= v ? 16'h0090 : 16'h00C0;
         6: batt_in <= v ? 16'h0100 : 16'h00C0;
         7: stop_request_in <= v;
         8: charge_in <= v ? 16'h0080 : 16'h00C0;
         9: ecu_fault_code_in <= v ? (seed[15:0] | 16'h0001) : 16'h0000;
         10: volt_b_in <= v ? 16'h0110 : 16'h00E6;
         11: cur_a_in <= v ? 16'h00C8 : 16'h0064;
         12: cur_b_in <= v ? 16'h0200 : 16'h0064;
         13: power_in <= v ? 16'shFF38 : 16'sh0000;
         14: mains_reversed_in <= v;
         16: mains_close_cmd_in <= v;
         18: gen_close_cmd_in <= v;
         19: rpm_in <= v ? 16'h0050 : 16'h05DC;
         20: service_expired_in <= v;
         21: nv_write_fail_in <= v;
         22: fuel_on_in <= !v;
         23: auto_mode_in <= !v;
         default: ;
      endcase
   endtask
   // Oldest note against the outputs whenever a probe shows up
   always @(posedge clk_in)
   begin
      cyc++;
      if (svc_seen == 1'b0 && service_reset_out === 1'b1)
         svc_seen <= 1'b1;
      if (probe_q && exp_q.size() > 0)
      begin
         obs = outs & msk_q.pop_front();
         expv = exp_q.pop_front();
         check_count++;
         if (obs !== expv)
         begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, obs, expv);
         end
      end
      if (cyc == 40000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   initial
   begin
      tick(10);
      rst_in <= 1'b0;
      tick(2);
      // Stops are watched even before the engine runs
      freq_in <= 16'h02A0;
      tick(4);
      note(24, 1'b0);
      freq_in <= 16'h02A1;
      rise(24, 0, 4);
      seed = xs(seed);
      freq_in <= 16'h01F4;
      // Stop must drop first, or the overspeed check proves nothing
      tick(3);
      note(24, 1'b0);
      rpm_in <= rpm_overshoot_in + 16'h0001 + {8'h00, seed[7:0]};
      rise(24, 0, 4);
      rpm_in <= 16'h05DC;
      set_cause(9, 1'b1);
      tick(6);
      note(24, 1'b0);
      set_cause(9, 1'b0);
      set_cause(0, 1'b1);
      tick(40);
      note(0, 1'b0);
      set_cause(0, 1'b0);
      $display("done: stops and holdoff gating");
      // Latching keeps a flag until the clear pulse
      latch_all_in <= 1'b1;
      set_cause(21, 1'b1);
      tick(2);
      set_cause(21, 1'b0);
      tick(6);
      note(21, 1'b1);
      warn_clear_in <= 1'b1;
      tick(1);
      warn_clear_in <= 1'b0;
      tick(3);
      note(21, 1'b0);
      latch_all_in <= 1'b0;
      $display("done: latching");
      engine_running_in <= 1'b1;
      rise(26, 4, 40);
      // Each cause except bits 15, 17 and 18 raises its flag in time, and the flag follows it away
      foreach (tb_bits[i])
      begin
         set_cause(tb_bits[i], 1'b1);
         // A healthy gen contact answers well inside the fail delay
         if (tb_bits[i] == 18)
         begin
            tick(16);
            note(18, 1'b0);
         end
         else
            rise(tb_bits[i], (28'h0F05300 >> tb_bits[i]) & 1 ? 0 : 5, 40);
         if (tb_bits[i] == 11)
            note(24, 1'b1);
         if (tb_bits[i] == 14)
            note(25, 1'b1);
         tick(24);
         set_cause(tb_bits[i], 1'b0);
         tick(6);
         note(tb_bits[i], 1'b0);
      end
      $display("done: warning table");
      // Two short pulses: only a restarting timer keeps the flag down
      repeat (2)
      begin
         set_cause(13, 1'b1);
         tick(4);
         set_cause(13, 1'b0);
         tick(4);
      end
      tick(16);
      note(13, 1'b0);
      $display("done: reverse power cancel");
      // Gen contact welded shut: opening it must report a fail to open
      set_cause(18, 1'b1);
      tick(12);
      gen_stuck <= 1'b1;
      set_cause(18, 1'b0);
      rise(17, 5, 40);
      gen_stuck <= 1'b0;
      tick(10);
      note(17, 1'b0);
      $display("done: contactor fail to open");
      svc_button_a_pin_in <= 1'b1;
      svc_button_b_pin_in <= 1'b1;
      rise(27, 5000 * TK - 10, 40);
      svc_button_a_pin_in <= 1'b0;
      svc_button_b_pin_in <= 1'b0;
      $display("done: service reset");
      tick(4);
      print_verdict();
   end
endmodule
`default_nettype wire
